/* File: core/sram_port_pkg.sv */
package sram_port_pkg;
	localparam int ADDR_W = 6;
	localparam int DEPTH = 64;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int DATA_W = 32;
	localparam int WORD_W = 36;
	localparam logic [3:0] LANES_NONE = 4'hf;
	localparam logic [1:0] BURST_FIRST = 2'h0;
	localparam logic [1:0] BURST_ONE = 2'h1;
	localparam logic [WORD_W-1:0] WORD_RST = 36'h0;

	typedef enum logic [2:0] {
		BURST_DESEL = 3'b001,
		BURST_READ = 3'b010,
		BURST_WRITE = 3'b100
	} burst_kind_t;
endpackage

/* File: core/burst_addr_step.sv */
`timescale 1ns/1ps
`default_nettype none
// low two address bits of the n-th access of a burst
module burst_addr_step (
	input wire logic [1:0] start_i,
	input wire logic [1:0] count_i,
	input wire logic interleave_i,
	output logic [1:0] addr_o
);
	always_comb begin
		if (interleave_i) begin
			addr_o = start_i ^ count_i;
		end else begin
			addr_o = 2'(start_i + count_i);
		end
	end
endmodule
`default_nettype wire

/* File: core/sram_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - burst order low: low two address bits count up, wrapping 11 to 00.
// - burst order high: low address bits are start XOR 01, 10, 11.
// - access selected only when all three chip selects are active.
// - select, load, write strobe high, qualify low starts a read burst.
// - step during a read ignores selects and strobe, advances, keeps reading.
// - read with output drive enable high is a dummy read, lines floating.
// - select, load, strobe low, any lane low starts a write burst.
// - step during write advances and writes the lanes driven that cycle.
// - write with all lanes high writes nothing, floats lines, still advances.
// - clock qualify high: edge ignored, address and pipeline held.
// - sleep request: within two cycles ignore inputs, float lines, keep contents.
// - any write cycle floats data and parity regardless of output enable.
// - after power-up deselected with lines floating.
// - output enable acts combinationally, masked in writes, gated by sleep.
// - any lane combination writes exactly the low-select lanes.
// - read data appears after the rising edge following the read start.
// - write data is latched at the second edge after the write start.
// - deselect floats the outputs after the next edge; stepping continues it.
module sram_port (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [sram_port_pkg::ADDR_W-1:0] addr_i,
	input wire logic chip_select_1_n_i,
	input wire logic chip_select_2_i,
	input wire logic chip_select_3_n_i,
	input wire logic load_or_step_i,
	input wire logic write_enable_n_i,
	input wire logic [sram_port_pkg::LANES-1:0] byte_lane_select_n_i,
	input wire logic clock_qualify_n_i,
	input wire logic sleep_request_i,
	input wire logic output_drive_n_i,
	input wire logic burst_order_i,
	input wire logic [sram_port_pkg::DATA_W-1:0] data_i,
	input wire logic [sram_port_pkg::LANES-1:0] parity_lines_i,
	output logic [sram_port_pkg::DATA_W-1:0] data_o,
	output logic [sram_port_pkg::LANES-1:0] parity_lines_o,
	output logic data_oe_o,
	output logic parity_lines_oe_o,
	output logic sleep_active_o
);
	import sram_port_pkg::*;

	typedef struct packed {
		logic sleep_s1;
		logic sleep_s2;
		burst_kind_t burst;
		logic [ADDR_W-1:0] base;
		logic [1:0] cnt;
		logic [ADDR_W-1:0] s1_addr;
		logic s1_rd;
		logic s1_wr;
		logic [LANES-1:0] s1_bw_n;
		logic s2_wr;
		logic [ADDR_W-1:0] s2_addr;
		logic [LANES-1:0] s2_bw_n;
		logic [WORD_W-1:0] dout;
		logic drive;
		logic [DEPTH-1:0][WORD_W-1:0] mem;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic [1:0] step_low;
	logic selected;
	logic go;
	logic [WORD_W-1:0] rd_word;

	// merge one incoming word into a stored word, lane by lane
	function automatic logic [WORD_W-1:0] merge_lanes(
		input logic [WORD_W-1:0] old_w,
		input logic [DATA_W-1:0] din,
		input logic [LANES-1:0] pin,
		input logic [LANES-1:0] bw_n
	);
		logic [WORD_W-1:0] w;
		w = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (!bw_n[i]) begin
				w[i*BYTE_W +: BYTE_W] = din[i*BYTE_W +: BYTE_W];
				w[DATA_W+i] = pin[i];
			end
		end
		return w;
	endfunction

	burst_addr_step u_step (
		.start_i(st_q.base[1:0]),
		.count_i(2'(st_q.cnt + BURST_ONE)),
		.interleave_i(burst_order_i),
		.addr_o(step_low)
	);

	assign selected = !chip_select_1_n_i && chip_select_2_i && !chip_select_3_n_i;
	// stalled edges freeze the access pipeline; sleep clears its read and write flags in the branch below
	assign go = !clock_qualify_n_i && !st_q.sleep_s2;

	always_comb begin
		st_d = st_q;
		rd_word = st_q.mem[st_q.s1_addr];
		// a write finishing on this edge is forwarded so back-to-back read sees it
		if (st_q.s2_wr && st_q.s2_addr == st_q.s1_addr) begin
			rd_word = merge_lanes(rd_word, data_i, parity_lines_i, st_q.s2_bw_n);
		end
		st_d.sleep_s1 = sleep_request_i;
		st_d.sleep_s2 = st_q.sleep_s1;
		if (st_q.sleep_s2) begin
			st_d.burst = BURST_DESEL;
			st_d.s1_rd = 1'b0;
			st_d.s1_wr = 1'b0;
			st_d.s2_wr = 1'b0;
			st_d.drive = 1'b0;
		end else if (go) begin
			if (st_q.s2_wr) begin
				st_d.mem[st_q.s2_addr] = merge_lanes(st_q.mem[st_q.s2_addr], data_i,
					parity_lines_i, st_q.s2_bw_n);
			end
			st_d.s2_wr = st_q.s1_wr;
			st_d.s2_addr = st_q.s1_addr;
			st_d.s2_bw_n = st_q.s1_bw_n;
			st_d.dout = rd_word;
			st_d.drive = st_q.s1_rd;
			if (!load_or_step_i) begin
				st_d.cnt = BURST_FIRST;
				st_d.base = addr_i;
				st_d.s1_addr = addr_i;
				st_d.s1_bw_n = byte_lane_select_n_i;
				if (!selected) begin
					st_d.burst = BURST_DESEL;
					st_d.s1_rd = 1'b0;
					st_d.s1_wr = 1'b0;
				end else if (write_enable_n_i) begin
					st_d.burst = BURST_READ;
					st_d.s1_rd = 1'b1;
					st_d.s1_wr = 1'b0;
				end else begin
					st_d.burst = BURST_WRITE;
					st_d.s1_rd = 1'b0;
					st_d.s1_wr = byte_lane_select_n_i != LANES_NONE;
				end
			end else begin
				// stepping ignores chip selects and write strobe entirely
				st_d.cnt = 2'(st_q.cnt + BURST_ONE);
				st_d.s1_addr = {st_q.base[ADDR_W-1:2], step_low};
				st_d.s1_bw_n = byte_lane_select_n_i;
				case (st_q.burst)
					BURST_READ: begin
						st_d.s1_rd = 1'b1;
						st_d.s1_wr = 1'b0;
					end
					BURST_WRITE: begin
						st_d.s1_rd = 1'b0;
						st_d.s1_wr = byte_lane_select_n_i != LANES_NONE;
					end
					BURST_DESEL: begin
						st_d.s1_rd = 1'b0;
						st_d.s1_wr = 1'b0;
					end
					default: begin
						st_d.burst = BURST_DESEL;
						st_d.s1_rd = 1'b0;
						st_d.s1_wr = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q.sleep_s1 <= 1'b0;
			st_q.sleep_s2 <= 1'b0;
			st_q.burst <= BURST_DESEL;
			st_q.base <= '0;
			st_q.cnt <= BURST_FIRST;
			st_q.s1_addr <= '0;
			st_q.s1_rd <= 1'b0;
			st_q.s1_wr <= 1'b0;
			st_q.s1_bw_n <= LANES_NONE;
			st_q.s2_wr <= 1'b0;
			st_q.s2_addr <= '0;
			st_q.s2_bw_n <= LANES_NONE;
			st_q.dout <= WORD_RST;
			st_q.drive <= 1'b0;
			st_q.mem <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign data_o = st_q.dout[DATA_W-1:0];
	assign parity_lines_o = st_q.dout[WORD_W-1:DATA_W];
	assign sleep_active_o = st_q.sleep_s2;
	// enable is the one path that bypasses the clock, so bus turnaround follows the pin at once
	assign data_oe_o = st_q.drive && !output_drive_n_i && !st_q.sleep_s2;
	assign parity_lines_oe_o = data_oe_o;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence seq_read_start;
		go && !load_or_step_i && selected && write_enable_n_i;
	endsequence
	sequence seq_next_live;
		!clock_qualify_n_i && !sleep_active_o;
	endsequence

	AST_LINEAR: assert property (go && load_or_step_i && !burst_order_i |=>
		st_q.s1_addr[1:0] == 2'($past(st_q.s1_addr[1:0]) + 2'h1))
		else $error("linear burst step wrong");
	AST_INTERLEAVE: assert property (go && load_or_step_i && burst_order_i |=>
		st_q.s1_addr[1:0] == (st_q.base[1:0] ^ st_q.cnt))
		else $error("interleaved burst step wrong");
	AST_SELECT: assert property (go && !load_or_step_i && !selected |=>
		!st_q.s1_rd && !st_q.s1_wr)
		else $error("access started while not selected");
	AST_READ_DATA: assert property (seq_read_start ##1 seq_next_live |=>
		st_q.drive && (data_oe_o == !output_drive_n_i))
		else $error("read data not driven one stage later");
	AST_DUMMY_READ: assert property (output_drive_n_i |-> !data_oe_o)
		else $error("lines driven with output enable high");
	AST_ABORT: assert property (go && !load_or_step_i && selected && !write_enable_n_i &&
		byte_lane_select_n_i == LANES_NONE |=> !st_q.s1_wr)
		else $error("aborted write still queued");
	AST_STALL: assert property (clock_qualify_n_i && !st_q.sleep_s2 |=>
		$stable(st_q.s1_addr) && $stable(st_q.drive) && $stable(st_q.dout))
		else $error("state moved on a stalled edge");
	AST_SLEEP: assert property (sleep_request_i ##1 sleep_request_i |=> !data_oe_o)
		else $error("lines driven two cycles into sleep");
	AST_WRITE_FLOAT: assert property (go && st_q.s1_wr |=> !data_oe_o)
		else $error("lines driven in a write data cycle");
	AST_DESELECT: assert property (go && !load_or_step_i && !selected ##1 seq_next_live
		|=> !data_oe_o)
		else $error("outputs still driven after deselect");
endmodule
`default_nettype wire

/* File: sim/sram_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// write data two live edges after the write cycle, scrambled when released
module sram_ctrl_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic live_i,
	input wire logic wr_i,
	input wire logic [35:0] word_i,
	output logic [31:0] data_o,
	output logic [3:0] parity_o
);
	logic [36:0] s1_q, s2_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (live_i) begin
			s2_q <= s1_q;
			s1_q <= {wr_i, word_i};
		end
	end
	// released lines show the inverse so a stale value never passes
	assign {parity_o, data_o} = s2_q[36] ? s2_q[35:0] : ~s2_q[35:0];
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sram_port_pkg::*;
	logic sys_clk_i = 0, rst_n_i = 0, cs1 = 1, cs2 = 0, cs3 = 1, ld = 0, wen = 1;
	logic cq = 0, slp = 0, oen = 1, mode = 0, wr = 0, prd = 0, drv = 0;
	logic [ADDR_W-1:0] addr = '0, ba = '0, pa = '0;
	logic [LANES-1:0] bw = LANES_NONE;
	logic [WORD_W-1:0] word = '0, expq = '0;
	logic [WORD_W-1:0] mem [DEPTH];
	logic [1:0] bc = '0, bk = '0;
	logic [46:0] p1 = '0, p2 = '0;
	logic [31:0] r;
	int fail_count = 0, samples_checked = 0, seed = 60, i;
	wire logic [DATA_W-1:0] din, dout;
	wire logic [LANES-1:0] pin, pout;
	wire logic oe, poe, sa;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	sram_port dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
		.chip_select_1_n_i(cs1), .chip_select_2_i(cs2), .chip_select_3_n_i(cs3),
		.load_or_step_i(ld), .write_enable_n_i(wen), .byte_lane_select_n_i(bw),
		.clock_qualify_n_i(cq), .sleep_request_i(slp), .output_drive_n_i(oen),
		.burst_order_i(mode), .data_i(din), .parity_lines_i(pin), .data_o(dout),
		.parity_lines_o(pout), .data_oe_o(oe), .parity_lines_oe_o(poe), .sleep_active_o(sa));
	sram_ctrl_model ctrl (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .live_i(!cq), .wr_i(wr),
		.word_i(word), .data_o(din), .parity_o(pin));
	task chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	function logic [1:0] nth(input logic [1:0] s, input logic [1:0] c, input logic m);
		return m ? s ^ c : s + c;
	endfunction
	// bench view of one live edge: land the old write, then take the new op
	task model;
		if (p2[46]) for (int k = 0; k < LANES; k++) if (!p2[36+k]) begin
			mem[p2[45:40]][8*k+:8] = p2[8*k+:8];
			mem[p2[45:40]][32+k] = p2[32+k];
		end
		drv = prd;
		if (prd) expq = mem[pa];
		if (!ld) begin
			bk = ({cs1, cs2, cs3} != 3'b010) ? 2'h0 : (wen ? 2'h1 : 2'h2);
			ba = addr;
			bc = 2'h0;
		end else bc++;
		pa = {ba[5:2], nth(ba[1:0], bc, mode)};
		prd = bk == 2'h1;
		p2 = p1;
		p1 = {bk == 2'h2, pa, bw, word};
	endtask
	// compare before driving: the enable follows its pin at once, so it is read with the level
	// that has stood since the last drive, never in the step that changes it
	task go(input logic rnd);
		@(posedge sys_clk_i);
		if (!cq) model();
		#1;
		chk(WORD_W'(oe), WORD_W'(drv & !oen));
		chk(WORD_W'(poe), WORD_W'(drv & !oen));
		if (drv & !oen) chk({pout, dout}, expq);
		if (rnd) begin
			r = $random(seed);
			cq = r[2:0] == 3'h0;
			ld = r[4:3] != 2'h0;
			wen = r[5];
			{cs1, cs2, cs3} = 3'b010 ^ (r[18:16] & {3{r[7:6] == 2'h0}});
			oen = r[8] & r[9];
			bw = r[14] ? LANES_NONE : r[13:10];
			addr = r[24:19];
			word = {$random(seed), r[31:28]};
			wr = ld ? bk == 2'h2 : ({cs1, cs2, cs3} == 3'b010 && !wen);
		end
	endtask
	task nap(input logic m);
		{cs1, cs2, cs3, ld, wen, wr, cq} = 7'b1100100;
		repeat (3) go(0);
		slp = 1;
		repeat (3) go(0);
		chk(WORD_W'(sa), WORD_W'(1));
		{cs1, cs2, cs3, ld, wen, oen} = 6'b010000;
		bw = '0;
		repeat (4) begin
			@(posedge sys_clk_i);
			#1 chk(WORD_W'(oe), '0);
		end
		{cs1, cs2, cs3, wen, slp, mode} = {5'b11010, m};
		repeat (3) go(0);
		chk(WORD_W'(sa), '0);
	endtask
	initial begin
		for (i = 0; i < DEPTH; i++) mem[i] = '0;
		repeat (20) @(posedge sys_clk_i);
		#1 rst_n_i = 1;
		for (i = 0; i < 2; i++) begin
			nap(i[0]);
			{cs1, cs2, cs3, ld, wen, wr, addr, bw, word} = {6'b010001, 6'h07, 4'h6, 36'h5a5a5a5a5};
			go(0);
			{ld, wen, wr, oen} = 4'b0100;
			go(0);
			ld = 1;
			repeat (5) go(0);
			repeat (3000) go(1);
			// one quiet edge so the last random drive is not overwritten in its own step
			go(0);
		end
		close_out();
	end
endmodule
`default_nettype wire
